// ### inc/cpu_regs_pkg.sv
/*
  Package for the CPU core register set: APB offsets, flag_word field
  positions, reset values, widths and the packed carriers shared by files.
  Assumes a 32-bit APB with one aligned word per register.
*/
package cpu_regs_pkg;

  localparam int          DATA_W      = 16;
  localparam int          ADDR20_W    = 20;
  localparam int          FLAG_W      = 11;
  localparam int          IPL_W       = 3;
  localparam int          NUM_DATA    = 4;
  localparam int          NUM_BANKS   = 2;
  localparam int          SWI_LIMIT   = 31;

  // APB byte offsets
  localparam logic [11:0] OFF_DATA0   = 12'h000;
  localparam logic [11:0] OFF_DATA1   = 12'h004;
  localparam logic [11:0] OFF_DATA2   = 12'h008;
  localparam logic [11:0] OFF_DATA3   = 12'h00C;
  localparam logic [11:0] OFF_ADDR0   = 12'h010;
  localparam logic [11:0] OFF_ADDR1   = 12'h014;
  localparam logic [11:0] OFF_FRAME   = 12'h018;
  localparam logic [11:0] OFF_VTB     = 12'h01C;
  localparam logic [11:0] OFF_PC      = 12'h020;
  localparam logic [11:0] OFF_USP     = 12'h024;
  localparam logic [11:0] OFF_ISP     = 12'h028;
  localparam logic [11:0] OFF_SB      = 12'h02C;
  localparam logic [11:0] OFF_FLAG    = 12'h030;
  localparam logic [11:0] OFF_ASP     = 12'h034;
  localparam logic [11:0] OFF_APAIR   = 12'h038;
  localparam logic [11:0] OFF_DPAIR   = 12'h03C;

  // flag_word field positions
  localparam int          FB_CARRY    = 0;
  localparam int          FB_TRACE    = 1;
  localparam int          FB_NULL     = 2;
  localparam int          FB_NEG      = 3;
  localparam int          FB_BANK     = 4;
  localparam int          FB_WRAP     = 5;
  localparam int          FB_MASK     = 6;
  localparam int          FB_STACK    = 7;
  localparam int          FB_IPL_LO   = 8;
  localparam int          FB_RSVD     = 11;

  localparam logic [10:0] FLAG_RESET  = 11'h000;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [19:0] REG20_RESET = 20'h00000;
  localparam logic [31:0] PSLVERR_OK  = 32'h0000_0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        valid;
    logic        carry;
    logic        null_res;
    logic        negative;
    logic        wrap;
  } alu_flags_t;

  typedef struct packed {
    logic        hw_ack;
    logic        swi_exec;
    logic [5:0]  swi_num;
    logic [19:0] vector_addr;
  } irq_event_t;

endpackage

// ### tb/cpu_core_register_set_tb.sv
/*
  Bench for cpu_core_register_set: APB master, datapath model and checks.
  Assumes one wait state per APB access and the offsets of the package.
*/
`timescale 1ns/1ns
module cpu_core_register_set_tb;
  import cpu_regs_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, er, pc_load, sp_load, gpr_we, req_valid, irq_accept;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, address_pair, data_pair_32;
  logic [3:0]  pstrb = 4'hF;
  alu_flags_t  alu_flags;
  irq_event_t  irq_event;
  logic [19:0] pc_next, program_counter, vector_table_base;
  logic [15:0] sp_next, gpr_wdata, active_sp, frame_base, static_base;
  logic [1:0]  gpr_idx, gpr_byte_en;
  logic [2:0]  req_priority;
  logic [10:0] flag_word;
  int          n_mismatch = 0, checked = 0;
  cpu_core_register_set dut (.*);
  datapath_model dp (.*);
  always #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_reset;
    apb(1'b0, OFF_FLAG, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({rdat[31:1], er}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    logic [11:0] offs[8] = '{OFF_ADDR0, OFF_ADDR1, OFF_FRAME, OFF_VTB, OFF_PC, OFF_USP, OFF_ISP, OFF_SB};
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, offs[i], 32'hFFFF_FFFF);
      apb(1'b0, offs[i], 32'h0);
      chk(rdat, (i == 3 || i == 4) ? 32'h000F_FFFF : 32'h0000_FFFF);
    end
    apb(1'b1, OFF_ADDR0, 32'h1234);
    apb(1'b1, OFF_ADDR1, 32'hBEEF);
    apb(1'b0, OFF_APAIR, 32'h0);
    chk(rdat, 32'hBEEF_1234);
    chk(address_pair, 32'hBEEF_1234);
    pstrb <= 4'h1;
    apb(1'b1, OFF_FRAME, 32'h0);
    pstrb <= 4'hF;
    chk(32'(frame_base), 32'h0000_FF00);
    chk(32'(vector_table_base), 32'h000F_FFFF);
    chk(32'(static_base), 32'h0000_FFFF);
    $display("t_regs done");
  endtask
  task automatic t_stack;
    apb(1'b1, OFF_USP, 32'h1111);
    apb(1'b1, OFF_ISP, 32'h2222);
    chk(32'(active_sp), 32'h2222);
    apb(1'b1, OFF_FLAG, 32'h080);
    apb(1'b0, OFF_ASP, 32'h0);
    chk(rdat, 32'h1111);
    dp.sp(16'h3333);
    apb(1'b0, OFF_USP, 32'h0);
    chk(rdat, 32'h3333);
    dp.pc(20'hA_BCDE);
    chk(32'(program_counter), 32'h000A_BCDE);
    dp.irq(1'b0, 6'd32, 20'h0);
    chk(32'(active_sp), 32'h3333);
    dp.irq(1'b0, 6'd31, 20'h0);
    chk(32'(active_sp), 32'h2222);
    apb(1'b1, OFF_FLAG, 32'h080);
    dp.irq(1'b1, 6'd0, 20'h4_5678);
    chk({1'b0, flag_word, program_counter}, {12'h000, 20'h4_5678});
    $display("t_stack done");
  endtask
  task automatic t_alu;
    logic [3:0] f[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hA};
    foreach (f[i]) begin
      dp.alu(f[i]);
      chk(32'(flag_word), 32'({f[i][0], 1'b0, f[i][1], f[i][2], 1'b0, f[i][3]}));
    end
    $display("t_alu done");
  endtask
  task automatic t_irq;
    // trace and reserved bits written as zero
    apb(1'b1, OFF_FLAG, 32'h3C0);
    dp.req(1'b1, 3'd3);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq_accept), 32'h0);
    dp.req(1'b1, 3'd4);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq_accept), 32'h1);
    apb(1'b1, OFF_FLAG, 32'h380);
    chk(32'(irq_accept), 32'h0);
    apb(1'b1, OFF_FLAG, 32'h3C0);
    dp.irq(1'b1, 6'd40, 20'h0_1000);
    chk(32'(flag_word[7:6]), 32'h0);
    // Accept output trails the cleared mask by one cycle
    @(posedge clk_sys);
    chk(32'(irq_accept), 32'h0);
    dp.req(1'b0, 3'd0);
    $display("t_irq done");
  endtask
  task automatic t_bank;
    dp.gpr(2'd0, 2'b11, 16'h1234);
    dp.gpr(2'd2, 2'b11, 16'hABCD);
    chk(data_pair_32, 32'hABCD_1234);
    apb(1'b1, OFF_FLAG, 32'h010);
    chk(data_pair_32, 32'h0);
    dp.gpr(2'd0, 2'b01, 16'h5566);
    apb(1'b0, OFF_DATA0, 32'h0);
    chk(rdat, 32'h0066);
    apb(1'b1, OFF_FLAG, 32'h000);
    apb(1'b0, OFF_DPAIR, 32'h0);
    chk(rdat, 32'hABCD_1234);
    $display("t_bank done");
  endtask
  task automatic t_rerst;
    apb(1'b1, OFF_FLAG, 32'h7FD);
    chk(32'(flag_word), 32'h7FD);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'(flag_word), 32'h0);
    $display("t_rerst done");
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_regs;
    t_stack;
    t_alu;
    t_irq;
    t_bank;
    t_rerst;
    conclude;
  end
  // Tests need well under 1000 cycles
  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
endmodule
bind cpu_core_register_set regset_checker chk_i (.*);

// ### tb/datapath_model.sv
/*
  Behavioural model of the execution datapath and interrupt acknowledge logic.
  Assumes its tasks are called one at a time, just after a rising edge.
*/
`timescale 1ns/1ns
module datapath_model (
  input  wire logic                clk_sys,
  output cpu_regs_pkg::alu_flags_t alu_flags,
  output cpu_regs_pkg::irq_event_t irq_event,
  output logic                     pc_load,
  output logic [19:0]              pc_next,
  output logic                     sp_load,
  output logic [15:0]              sp_next,
  output logic                     gpr_we,
  output logic [1:0]               gpr_idx,
  output logic [1:0]               gpr_byte_en,
  output logic [15:0]              gpr_wdata,
  output logic                     req_valid,
  output logic [2:0]               req_priority
);
  import cpu_regs_pkg::*;
  initial begin
    {alu_flags, irq_event, pc_load, pc_next, sp_load, sp_next} = '0;
    {gpr_we, gpr_idx, gpr_byte_en, gpr_wdata, req_valid, req_priority} = '0;
  end
  // Released data shows the inverse so a stale value never passes
  // one strobe per ALU outcome
  task automatic alu(input logic [3:0] f);
    alu_flags <= {1'b1, f};
    @(posedge clk_sys);
    alu_flags <= {1'b0, ~f};
    @(posedge clk_sys);
  endtask
  task automatic irq(input logic hw, input logic [5:0] n, input logic [19:0] v);
    irq_event <= {hw, ~hw, n, v};
    @(posedge clk_sys);
    irq_event <= {2'b00, ~n, ~v};
    @(posedge clk_sys);
  endtask
  task automatic pc(input logic [19:0] v);
    pc_load <= 1'b1;
    pc_next <= v;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    pc_next <= ~v;
    @(posedge clk_sys);
  endtask
  task automatic sp(input logic [15:0] v);
    sp_load <= 1'b1;
    sp_next <= v;
    @(posedge clk_sys);
    sp_load <= 1'b0;
    sp_next <= ~v;
    @(posedge clk_sys);
  endtask
  task automatic gpr(input logic [1:0] i, input logic [1:0] b, input logic [15:0] d);
    gpr_we <= 1'b1;
    gpr_idx <= i;
    gpr_byte_en <= b;
    gpr_wdata <= d;
    @(posedge clk_sys);
    gpr_we <= 1'b0;
    gpr_wdata <= ~d;
    @(posedge clk_sys);
  endtask
  task automatic req(input logic v, input logic [2:0] p);
    req_valid <= v;
    req_priority <= p;
  endtask
endmodule

// ### tb/regset_checker.sv
/*
  Assertion checker on the register set ports.
  Assumes it is bound into the top module; one clock domain.
*/
`timescale 1ns/1ns
module regset_checker (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire cpu_regs_pkg::alu_flags_t alu_flags,
  input wire cpu_regs_pkg::irq_event_t irq_event,
  input wire logic                     pc_load,
  input wire logic [19:0]              pc_next,
  input wire logic                     req_valid,
  input wire logic [2:0]               req_priority,
  input wire logic                     irq_accept,
  input wire logic [19:0]              program_counter,
  input wire logic [10:0]              flag_word
);
  import cpu_regs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // An APB write in flight outranks datapath updates, so skip those cycles
  logic apw;
  assign apw = psel && penable && pwrite;
  property p_rst; $rose(rst_n) |-> flag_word == 11'h000; endproperty
  a_rst: assert property (p_rst) else $error("flag word not clear after reset");
  property p_cy; alu_flags.valid && !apw |=> flag_word[0] == $past(alu_flags.carry); endproperty
  a_cy: assert property (p_cy) else $error("carry flag not loaded");
  property p_zs;
    alu_flags.valid && !apw |=> {flag_word[5], flag_word[3:2]} ==
      $past({alu_flags.wrap, alu_flags.negative, alu_flags.null_res});
  endproperty
  a_zs: assert property (p_zs) else $error("result flags wrong");
  property p_mask; irq_event.hw_ack || irq_event.swi_exec |=> !flag_word[6]; endproperty
  a_mask: assert property (p_mask) else $error("mask gate kept");
  property p_stk;
    irq_event.hw_ack || (irq_event.swi_exec && irq_event.swi_num <= 6'd31) |=> !flag_word[7];
  endproperty
  a_stk: assert property (p_stk) else $error("stack select kept");
  property p_blk; !flag_word[6] |=> !irq_accept; endproperty
  a_blk: assert property (p_blk) else $error("accepted while masked");
  property p_lvl; req_priority <= flag_word[10:8] |=> !irq_accept; endproperty
  a_lvl: assert property (p_lvl) else $error("accepted at low level");
  property p_acc; req_valid && flag_word[6] && req_priority > flag_word[10:8] |=> irq_accept; endproperty
  a_acc: assert property (p_acc) else $error("request not accepted");
  property p_pc;
    pc_load && !irq_event.hw_ack && !irq_event.swi_exec && !apw |=> program_counter == $past(pc_next);
  endproperty
  a_pc: assert property (p_pc) else $error("program counter not loaded");
  c_acc: cover property (irq_accept);
  c_swi: cover property (irq_event.swi_exec);
  c_alu: cover property (alu_flags.valid);
endmodule

// ### verilog/apb_decode.sv
/*
  APB address decoder for the register set: turns a byte address into a
  one-hot select and an unmapped flag. Assumes aligned word offsets.
*/
`timescale 1ns/1ns
module apb_decode (
  input  wire logic [11:0] paddr,
  output logic [15:0]      sel,
  output logic             unmapped
);
  import cpu_regs_pkg::*;

  always_comb begin
    sel      = 16'h0000;
    unmapped = 1'b0;
    if (paddr[1:0] != 2'h0 || paddr > OFF_DPAIR) begin
      unmapped = 1'b1;
    end else begin
      sel[paddr[5:2]] = 1'b1;
    end
  end
endmodule

// ### verilog/cpu_core_register_set.sv
/*
  Programmer-visible register set of a 16-bit CPU core, reached over APB and
  updated by the execution datapath and interrupt acknowledge logic.
  Assumes the datapath presents one-cycle strobes synchronous to clk_sys.
*/
// Summary of operation
// - address_reg_0/1 are 16 bits and pair into 32-bit address_pair.
// - frame_base is 16 bits, base for frame-relative addressing.
// - vector_table_base is 20 bits, start of interrupt vector table.
// - program_counter is 20 bits, address of next instruction.
// - Two 16-bit stack pointers; exactly one is active.
// - stack_select 0 picks interrupt stack, 1 picks user stack.
// - Hardware ack or software interrupt 0 to 31 clears stack_select.
// - static_base is 16 bits, base for static-relative addressing.
// - flag_word is 11 bits and shows processor state.
// - borrow_out_bit takes the latest ALU carry, borrow or shift-out.
// - null_result is 1 for a zero result, else 0.
// - negative_bit is 1 for a negative result, else 0.
// - register_group_sel picks general register bank 0 or 1.
// - arith_wrap_flag is 1 on overflow, else 0.
// - Maskable interrupts blocked while mask_gate is 0.
// - Acknowledging an interrupt clears mask_gate.
// - 3-bit priority level; accept only strictly higher requests.
// - Reserved flag bit written as 0; reads undefined (here zero).
// - Four 16-bit data registers, byte-splittable; reg 2 and 0 pair.
`timescale 1ns/1ns
module cpu_core_register_set #(
  parameter int NUM_BANKS = cpu_regs_pkg::NUM_BANKS
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire cpu_regs_pkg::alu_flags_t alu_flags,
  input  wire cpu_regs_pkg::irq_event_t irq_event,
  input  wire logic                     pc_load,
  input  wire logic [19:0]              pc_next,
  input  wire logic                     sp_load,
  input  wire logic [15:0]              sp_next,
  input  wire logic                     gpr_we,
  input  wire logic [1:0]               gpr_idx,
  input  wire logic [1:0]               gpr_byte_en,
  input  wire logic [15:0]              gpr_wdata,
  input  wire logic                     req_valid,
  input  wire logic [2:0]               req_priority,
  output logic                          irq_accept,
  output logic      [15:0]              active_sp,
  output logic      [31:0]              address_pair,
  output logic      [31:0]              data_pair_32,
  output logic      [19:0]              program_counter,
  output logic      [19:0]              vector_table_base,
  output logic      [15:0]              frame_base,
  output logic      [15:0]              static_base,
  output logic      [10:0]              flag_word
);
  import cpu_regs_pkg::*;

  typedef struct packed {
    logic [NUM_BANKS-1:0][NUM_DATA-1:0][15:0] data_reg;
    logic [15:0] address_reg_0;
    logic [15:0] address_reg_1;
    logic [15:0] frame_base;
    logic [19:0] vector_table_base;
    logic [19:0] program_counter;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] static_base;
    logic [10:0] flag_word;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_accept;
    logic [15:0] active_sp;
    logic [31:0] address_pair;
    logic [31:0] data_pair_32;
  } state_t;

  state_t      st_q;
  state_t      st_d;
  logic [15:0] sel;
  logic        unmapped;
  logic        accept;
  logic        bank;
  logic        wr_en;

  // Byte-lane merge used for every APB register write except the two pair offsets
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  apb_decode u_dec (
    .paddr    (paddr),
    .sel      (sel),
    .unmapped (unmapped)
  );

  irq_gate u_gate (
    .mask_gate          (st_q.flag_word[FB_MASK]),
    .cpu_priority_level (st_q.flag_word[FB_IPL_LO +: IPL_W]),
    .req_valid          (req_valid),
    .req_priority       (req_priority),
    .accept             (accept)
  );

  assign bank  = st_q.flag_word[FB_BANK];
  // The held access cycle after pready must not write a second time
  assign wr_en = psel && penable && pwrite && !unmapped && !st_q.pready;

  always_comb begin
    st_d            = st_q;
    st_d.pready     = 1'b0;
    st_d.pslverr    = 1'b0;
    st_d.irq_accept = accept;

    // Datapath writes come first so APB writes in the same cycle win
    if (pc_load) begin
      st_d.program_counter = pc_next;
    end
    if (gpr_we) begin
      if (gpr_byte_en[0]) begin
        st_d.data_reg[bank][gpr_idx][7:0] = gpr_wdata[7:0];
      end
      if (gpr_byte_en[1]) begin
        st_d.data_reg[bank][gpr_idx][15:8] = gpr_wdata[15:8];
      end
    end
    if (sp_load) begin
      if (st_q.flag_word[FB_STACK]) begin
        st_d.user_stack_pointer = sp_next;
      end else begin
        st_d.interrupt_stack_pointer = sp_next;
      end
    end
    if (alu_flags.valid) begin
      st_d.flag_word[FB_CARRY] = alu_flags.carry;
      st_d.flag_word[FB_NULL]  = alu_flags.null_res;
      st_d.flag_word[FB_NEG]   = alu_flags.negative;
      st_d.flag_word[FB_WRAP]  = alu_flags.wrap;
    end

    // APB access phase; one wait state, a single pready pulse per access
    if (psel && penable && !st_q.pready) begin
      st_d.pready  = 1'b1;
      st_d.pslverr = unmapped;
    end
    if (psel && !penable) begin
      st_d.prdata = PSLVERR_OK;
      case (1'b1)
        sel[0], sel[1], sel[2], sel[3]: st_d.prdata = {16'h0000, st_q.data_reg[bank][paddr[3:2]]};
        sel[4]:  st_d.prdata = {16'h0000, st_q.address_reg_0};
        sel[5]:  st_d.prdata = {16'h0000, st_q.address_reg_1};
        sel[6]:  st_d.prdata = {16'h0000, st_q.frame_base};
        sel[7]:  st_d.prdata = {12'h000, st_q.vector_table_base};
        sel[8]:  st_d.prdata = {12'h000, st_q.program_counter};
        sel[9]:  st_d.prdata = {16'h0000, st_q.user_stack_pointer};
        sel[10]: st_d.prdata = {16'h0000, st_q.interrupt_stack_pointer};
        sel[11]: st_d.prdata = {16'h0000, st_q.static_base};
        sel[12]: st_d.prdata = {21'h000000, st_q.flag_word};
        sel[13]: st_d.prdata = {16'h0000, st_q.active_sp};
        sel[14]: st_d.prdata = st_q.address_pair;
        sel[15]: st_d.prdata = st_q.data_pair_32;
        default: st_d.prdata = PSLVERR_OK;
      endcase
    end
    if (wr_en) begin
      case (1'b1)
        sel[0], sel[1], sel[2], sel[3]:
          st_d.data_reg[bank][paddr[3:2]] = 16'(merge({16'h0000, st_q.data_reg[bank][paddr[3:2]]}, pwdata, pstrb));
        sel[4]:  st_d.address_reg_0 = 16'(merge({16'h0000, st_q.address_reg_0}, pwdata, pstrb));
        sel[5]:  st_d.address_reg_1 = 16'(merge({16'h0000, st_q.address_reg_1}, pwdata, pstrb));
        sel[6]:  st_d.frame_base = 16'(merge({16'h0000, st_q.frame_base}, pwdata, pstrb));
        sel[7]:  st_d.vector_table_base = 20'(merge({12'h000, st_q.vector_table_base}, pwdata, pstrb));
        sel[8]:  st_d.program_counter = 20'(merge({12'h000, st_q.program_counter}, pwdata, pstrb));
        sel[9]:  st_d.user_stack_pointer = 16'(merge({16'h0000, st_q.user_stack_pointer}, pwdata, pstrb));
        sel[10]: st_d.interrupt_stack_pointer = 16'(merge({16'h0000, st_q.interrupt_stack_pointer}, pwdata, pstrb));
        sel[11]: st_d.static_base = 16'(merge({16'h0000, st_q.static_base}, pwdata, pstrb));
        sel[12]: st_d.flag_word = 11'(merge({21'h000000, st_q.flag_word}, pwdata, pstrb));
        sel[14]: begin
          st_d.address_reg_0 = pwdata[15:0];
          st_d.address_reg_1 = pwdata[31:16];
        end
        sel[15]: begin
          st_d.data_reg[bank][0] = pwdata[15:0];
          st_d.data_reg[bank][2] = pwdata[31:16];
        end
        default: ;
      endcase
    end

    // Interrupt entry overrides software flag writes in the same cycle
    if (irq_event.hw_ack) begin
      st_d.flag_word[FB_MASK] = 1'b0;
      st_d.flag_word[FB_STACK] = 1'b0;
      // vector address loaded as given, not offset by vector_table_base
      st_d.program_counter = irq_event.vector_addr;
    end
    if (irq_event.swi_exec) begin
      st_d.flag_word[FB_MASK] = 1'b0;
      if (irq_event.swi_num <= 6'(SWI_LIMIT)) begin
        st_d.flag_word[FB_STACK] = 1'b0;
      end
      st_d.program_counter = irq_event.vector_addr;
    end

    st_d.active_sp    = st_d.flag_word[FB_STACK] ? st_d.user_stack_pointer : st_d.interrupt_stack_pointer;
    st_d.address_pair = {st_d.address_reg_1, st_d.address_reg_0};
    st_d.data_pair_32 = {st_d.data_reg[st_d.flag_word[FB_BANK]][2], st_d.data_reg[st_d.flag_word[FB_BANK]][0]};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.flag_word <= FLAG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata            = st_q.prdata;
  assign pready            = st_q.pready;
  assign pslverr           = st_q.pslverr;
  assign irq_accept        = st_q.irq_accept;
  assign active_sp         = st_q.active_sp;
  assign address_pair      = st_q.address_pair;
  assign data_pair_32      = st_q.data_pair_32;
  assign program_counter   = st_q.program_counter;
  assign vector_table_base = st_q.vector_table_base;
  assign frame_base        = st_q.frame_base;
  assign static_base       = st_q.static_base;
  assign flag_word         = st_q.flag_word;
endmodule

// ### verilog/irq_gate.sv
/*
  Interrupt acceptance gate: decides whether a maskable request of a given
  priority may be taken. Assumes flag_word fields are registered upstream.
*/
`timescale 1ns/1ns
module irq_gate (
  input  wire logic       mask_gate,
  input  wire logic [2:0] cpu_priority_level,
  input  wire logic       req_valid,
  input  wire logic [2:0] req_priority,
  output logic            accept
);
  import cpu_regs_pkg::*;

  always_comb begin
    accept = req_valid && mask_gate && (req_priority > cpu_priority_level);
  end
endmodule
